// ==== rtl/fault_log_control.sv ====
// Overview of operation
// - a host write of 1 to the force bit writes one log record, or none when full with wrap off, then the bit clears itself.
// - a host write of 1 to the erase bit fills every log byte with ff, then the bit clears itself.
// - a failed forced write or erase raises the comms/memory error flag and leaves the detail status clear.
// - monitoring is suspended for the whole of an erase.
// - unused setup bits always read zero.
// - the first-sample source bit picks the stored periodic result or a fresh conversion for the first slot.
// - with wrap off logging stops when full, with wrap on older records are overwritten.
// - the span field selects interval and log span 5/15, 20/60, 80/240 or 160/480 ms.
// - each trigger bit logs a record when its enabled fault line is pulled low.
// - when wrapping and full, space is freed two records at a time before writing.
`default_nettype none
module fault_log_control #(
  parameter int log_records = 32,
  parameter int log_bytes = 256
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fault_log_pkg::cmd_req_t cmd_in,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  input wire logic [3:0] fault_line_in,
  input wire logic [3:0] line_enable,
  input wire logic nv_done,
  input wire logic nv_error,
  input wire logic conv_done,
  output fault_log_pkg::nv_req_t nv_out,
  output logic [7:0] nv_addr,
  output logic conv_start,
  output logic monitor_hold,
  output logic comms_memory_error_flag,
  output logic [7:0] comms_detail_status,
  output logic [31:0] interval_cycles,
  output logic [31:0] depth_cycles
);
  localparam int rec_w = $clog2(log_records + 1);
  localparam int byte_w = $clog2(log_bytes);
  localparam logic [rec_w-1:0] rec_full = rec_w'(log_records);
  localparam logic [byte_w-1:0] byte_last = byte_w'(log_bytes - 1);

  fault_log_pkg::log_state_t state_q, state_d;
  logic [15:0] setup_q;
  logic [rec_w-1:0] used_q;
  logic [byte_w-1:0] ebyte_q;
  logic [3:0] line_s1_q, line_s2_q, line_prev_q;
  logic [15:0] cmd_rdata_q;
  logic cmd_rvalid_q, conv_q, hold_q, err_q, nvreq_q, nver_q, nvfresh_q, forced_q;

  wire write_setup = cmd_in.req && cmd_in.wr && cmd_in.addr == fault_log_pkg::setup_cmd;
  wire read_setup = cmd_in.req && !cmd_in.wr && cmd_in.addr == fault_log_pkg::setup_cmd;
  wire idle = state_q == fault_log_pkg::st_idle;
  wire [3:0] trig_bits;
  wire [3:0] line_fall;
  wire line_hit = |line_fall;
  wire wrap_on = setup_q[fault_log_pkg::wrap_bit];
  wire log_full = used_q >= rec_full;
  wire fresh_src = setup_q[fault_log_pkg::src_bit];
  wire [1:0] span_sel = setup_q[fault_log_pkg::span_lo +: 2];
  wire start_force = idle && setup_q[fault_log_pkg::force_bit];
  wire start_erase = idle && setup_q[fault_log_pkg::erase_bit];
  wire start_line = idle && line_hit && !setup_q[fault_log_pkg::force_bit] && !setup_q[fault_log_pkg::erase_bit];
  wire want_log = start_force || start_line;
  wire log_blocked = log_full && !wrap_on;
  wire op_end = nv_done && (state_q == fault_log_pkg::st_write || state_q == fault_log_pkg::st_erase);
  wire erase_end = state_q == fault_log_pkg::st_erase && nv_done && ebyte_q == byte_last;
  wire write_end = state_q == fault_log_pkg::st_write && nv_done;
  wire free_end = state_q == fault_log_pkg::st_free && nv_done;
  wire busy_force = setup_q[fault_log_pkg::force_bit];
  wire force_clr = (start_force && log_blocked) || (write_end && forced_q);
  wire erase_clr = state_q == fault_log_pkg::st_erase && nv_done && (nv_error || erase_end);
  wire [1:0] act_keep = setup_q[15:14] & ~{force_clr, erase_clr};
  wire [15:0] wr_masked = cmd_in.wdata & fault_log_pkg::setup_keep_mask;
  wire [15:0] readback = setup_q & (fault_log_pkg::setup_keep_mask | 16'hc000);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_line
      // line 0 sits on the highest trigger bit
      assign trig_bits[gi] = setup_q[fault_log_pkg::trig_lo + 3 - gi];
      assign line_fall[gi] = trig_bits[gi] && line_enable[gi] && line_prev_q[gi] && !line_s2_q[gi];
    end
  endgenerate

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fault_log_pkg::st_idle:
        if (start_erase)
          state_d = fault_log_pkg::st_erase;
        else if (want_log && !(log_blocked && start_line))
          state_d = fresh_src ? fault_log_pkg::st_convert : fault_log_pkg::st_write;
      fault_log_pkg::st_convert:
        if (conv_done)
          state_d = (log_full && wrap_on) ? fault_log_pkg::st_free : fault_log_pkg::st_write;
      fault_log_pkg::st_free:
        if (nv_done)
          state_d = fault_log_pkg::st_write;
      fault_log_pkg::st_write:
        if (nv_done)
          state_d = fault_log_pkg::st_idle;
      fault_log_pkg::st_erase:
        if (nv_done && (nv_error || ebyte_q == byte_last))
          state_d = fault_log_pkg::st_idle;
      default:
        state_d = fault_log_pkg::st_idle;
    endcase
    if (state_q == fault_log_pkg::st_idle && state_d == fault_log_pkg::st_write && log_full && wrap_on)
      state_d = fault_log_pkg::st_free;
    if (start_force && log_blocked)
      state_d = fault_log_pkg::st_idle;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      line_s1_q <= 4'hf;
      line_s2_q <= 4'hf;
      line_prev_q <= 4'hf;
    end
    else
    begin
      line_s1_q <= fault_line_in;
      line_s2_q <= line_s1_q;
      line_prev_q <= line_s2_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= fault_log_pkg::st_idle;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      setup_q <= fault_log_pkg::setup_reset;
    else if (write_setup)
      setup_q <= wr_masked | {cmd_in.wdata[15:14] | act_keep, 14'h0000};
    else if (force_clr)
      setup_q[fault_log_pkg::force_bit] <= 1'b0;
    else if (erase_clr)
      setup_q[fault_log_pkg::erase_bit] <= 1'b0;
  end

  // marks a write started by the force bit, not by a line
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      forced_q <= 1'b0;
    else if (idle)
      forced_q <= start_force && !start_erase;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      used_q <= '0;
    else if (erase_end)
      used_q <= '0;
    else if (free_end && !nv_error)
      used_q <= used_q - rec_w'(fault_log_pkg::free_step);
    else if (write_end && !nv_error && !log_full)
      used_q <= used_q + rec_w'(1);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ebyte_q <= '0;
    else if (start_erase)
      ebyte_q <= '0;
    else if (state_q == fault_log_pkg::st_erase && nv_done)
      ebyte_q <= ebyte_q + byte_w'(1);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      err_q <= 1'b0;
    else if (op_end && nv_error && busy_force | setup_q[fault_log_pkg::erase_bit])
      err_q <= 1'b1;
    else if (write_setup)
      err_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmd_rdata_q <= 16'h0000;
      cmd_rvalid_q <= 1'b0;
      conv_q <= 1'b0;
      hold_q <= 1'b0;
      nvreq_q <= 1'b0;
      nver_q <= 1'b0;
      nvfresh_q <= 1'b0;
    end
    else
    begin
      cmd_rdata_q <= readback;
      cmd_rvalid_q <= read_setup;
      conv_q <= state_d == fault_log_pkg::st_convert && state_q != fault_log_pkg::st_convert;
      hold_q <= state_d == fault_log_pkg::st_erase;
      nvreq_q <= state_d == fault_log_pkg::st_write || state_d == fault_log_pkg::st_erase
                 || state_d == fault_log_pkg::st_free;
      nver_q <= state_d == fault_log_pkg::st_erase || state_d == fault_log_pkg::st_free;
      nvfresh_q <= fresh_src;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      interval_cycles <= 32'h0;
      depth_cycles <= 32'h0;
    end
    else
    begin
      case (span_sel)
        2'h0:
        begin
          interval_cycles <= 32'(fault_log_pkg::span_ms_0 * fault_log_pkg::cyc_per_ms);
          depth_cycles <= 32'(fault_log_pkg::depth_ms_0 * fault_log_pkg::cyc_per_ms);
        end
        2'h1:
        begin
          interval_cycles <= 32'(fault_log_pkg::span_ms_1 * fault_log_pkg::cyc_per_ms);
          depth_cycles <= 32'(fault_log_pkg::depth_ms_1 * fault_log_pkg::cyc_per_ms);
        end
        2'h2:
        begin
          interval_cycles <= 32'(fault_log_pkg::span_ms_2 * fault_log_pkg::cyc_per_ms);
          depth_cycles <= 32'(fault_log_pkg::depth_ms_2 * fault_log_pkg::cyc_per_ms);
        end
        default:
        begin
          interval_cycles <= 32'(fault_log_pkg::span_ms_3 * fault_log_pkg::cyc_per_ms);
          depth_cycles <= 32'(fault_log_pkg::depth_ms_3 * fault_log_pkg::cyc_per_ms);
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      nv_addr <= 8'h00;
    else if (state_d == fault_log_pkg::st_erase)
      nv_addr <= 8'(state_q != fault_log_pkg::st_erase ? byte_w'(0) : nv_done ? ebyte_q + byte_w'(1) : ebyte_q);
    else
      nv_addr <= 8'(used_q);
  end

  assign cmd_rdata = cmd_rdata_q;
  assign cmd_rvalid = cmd_rvalid_q;
  assign conv_start = conv_q;
  assign monitor_hold = hold_q;
  assign comms_memory_error_flag = err_q;
  assign comms_detail_status = 8'h00;
  assign nv_out = '{req: nvreq_q, erase: nver_q, fresh: nvfresh_q, data: fault_log_pkg::erase_byte};
endmodule : fault_log_control
`default_nettype wire

// ==== rtl/fault_log_pkg.sv ====
`default_nettype none
package fault_log_pkg;
  localparam logic [7:0] setup_cmd = 8'hd8;
  localparam int force_bit = 15;
  localparam int erase_bit = 14;
  localparam int src_bit = 10;
  localparam int wrap_bit = 9;
  localparam int span_lo = 7;
  localparam int trig_lo = 3;
  localparam logic [15:0] setup_reset = 16'h0000;
  localparam logic [15:0] setup_keep_mask = 16'h07f8;
  localparam logic [7:0] erase_byte = 8'hff;
  localparam int clk_mhz = 125;
  localparam int span_ms_0 = 5;
  localparam int span_ms_1 = 20;
  localparam int span_ms_2 = 80;
  localparam int span_ms_3 = 160;
  localparam int depth_ms_0 = 15;
  localparam int depth_ms_1 = 60;
  localparam int depth_ms_2 = 240;
  localparam int depth_ms_3 = 480;
  localparam int cyc_per_ms = clk_mhz * 1000;
  localparam logic [1:0] free_step = 2'h2;

  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic req;
    logic erase;
    logic fresh;
    logic [7:0] data;
  } nv_req_t;

  typedef enum logic [2:0] {st_idle, st_convert, st_free, st_write, st_erase} log_state_t;
endpackage : fault_log_pkg
`default_nettype wire

// ==== verification/fault_log_monitor.sv ====
`default_nettype none
module fault_log_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fault_log_pkg::cmd_req_t cmd_in,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic nv_done,
  input wire logic nv_error,
  input wire fault_log_pkg::nv_req_t nv_out,
  input wire logic [7:0] nv_addr,
  input wire logic monitor_hold,
  input wire logic comms_memory_error_flag,
  input wire logic [7:0] comms_detail_status,
  input wire logic [31:0] interval_cycles,
  input wire logic [31:0] depth_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_rd; cmd_in.req && !cmd_in.wr && cmd_in.addr == 8'hd8; endsequence
  sequence s_ers; cmd_in.req && cmd_in.wr && cmd_in.addr == 8'hd8 && cmd_in.wdata[14]; endsequence
  property p_read; s_rd |=> cmd_rvalid && (cmd_rdata & 16'h3807) == 16'h0000; endproperty
  a_read: assert property (p_read) else $error("bad read");
  property p_det; comms_detail_status == 8'h00; endproperty
  a_det: assert property (p_det) else $error("detail set");
  sequence s_fail; nv_done && nv_error && (monitor_hold || (cmd_rdata[15] && !nv_out.erase)); endsequence
  property p_err; s_fail |=> comms_memory_error_flag; endproperty
  a_err: assert property (p_err) else $error("no error flag");
  property p_hold; monitor_hold |-> nv_out.req && nv_out.erase; endproperty
  a_hold: assert property (p_hold) else $error("hold alone");
  property p_ff; nv_out.req |-> nv_out.data == 8'hff; endproperty
  a_ff: assert property (p_ff) else $error("fill not ff");
  property p_span; depth_cycles == interval_cycles * 32'h3; endproperty
  a_span: assert property (p_span) else $error("span mismatch");
  property p_ers; s_ers |-> ##[1:3] monitor_hold; endproperty
  a_ers: assert property (p_ers) else $error("no hold");
  property p_step; monitor_hold && nv_done && !nv_error |=> !monitor_hold || nv_addr == $past(nv_addr) + 8'h1; endproperty
  a_step: assert property (p_step) else $error("byte skipped");
endmodule : fault_log_monitor
`default_nettype wire

// ==== verification/nv_store_model.sv ====
`default_nettype none
module nv_store_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fault_log_pkg::nv_req_t nv_in,
  input wire logic conv_start,
  input wire logic slow,
  input wire logic bad,
  output logic nv_done,
  output logic nv_error,
  output logic conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic hit;
  // one done per request, prompt or slow
  assign hit = nv_in.req && !nv_done && cnt_q == (slow ? 4'h9 : 4'h2);
  always_ff @(posedge clk_sys)
  begin
    cnt_q <= nv_in.req && !nv_done && !hit && !rst ? cnt_q + 4'h1 : 4'h0;
    nv_done <= hit && !rst;
    // error toggles outside a done pulse
    nv_error <= rst ? 1'b0 : hit ? bad : !nv_error;
    conv_done <= conv_start && !rst;
  end
endmodule : nv_store_model
`default_nettype wire

// ==== verification/fault_log_control_bench.sv ====
`default_nettype none
module fault_log_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, nv_done, nv_error, conv_done, slow, bad;
  logic cmd_rvalid, conv_start, monitor_hold, comms_memory_error_flag;
  logic [15:0] cmd_rdata;
  logic [3:0] fault_line_in, line_enable;
  logic [7:0] nv_addr, comms_detail_status;
  logic [31:0] interval_cycles, depth_cycles;
  fault_log_pkg::cmd_req_t cmd_in;
  fault_log_pkg::nv_req_t nv_out;
  int err_count, checks_done, cyc, convs, dones;
  fault_log_control #(.log_records(4), .log_bytes(256)) dut_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd_in(cmd_in),
    .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid),
    .fault_line_in(fault_line_in),
    .line_enable(line_enable),
    .nv_done(nv_done),
    .nv_error(nv_error),
    .conv_done(conv_done),
    .nv_out(nv_out),
    .nv_addr(nv_addr),
    .conv_start(conv_start),
    .monitor_hold(monitor_hold),
    .comms_memory_error_flag(comms_memory_error_flag),
    .comms_detail_status(comms_detail_status),
    .interval_cycles(interval_cycles),
    .depth_cycles(depth_cycles)
  );
  nv_store_model mem_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .nv_in(nv_out),
    .conv_start(conv_start),
    .slow(slow),
    .bad(bad),
    .nv_done(nv_done),
    .nv_error(nv_error),
    .conv_done(conv_done)
  );
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    convs <= convs + (conv_start === 1'b1);
    dones <= dones + (nv_done === 1'b1 && monitor_hold === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input string n, input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) err_count++;
    if (s !== e) $display("BAD %s expected %h seen %h", n, e, s);
  endtask : cmp
  task automatic acc(input logic w, input logic [15:0] d);
    @(posedge clk_sys);
    cmd_in <= '{1'b1, w, 8'hd8, d};
    @(posedge clk_sys);
    cmd_in.req <= 1'b0;
  endtask : acc
  task automatic rd(input logic [15:0] e);
    acc(1'b0, 16'h0000);
    #1 cmp("setup", 40'({cmd_rvalid, cmd_rdata}), 40'({1'b1, e}));
  endtask : rd
  task automatic idle;
    int q;
    q = 0;
    #1;
    for (int i = 0; i < 4000 && q < 8; i++) #8 q = nv_out.req === 1'b0 ? q + 1 : 0;
  endtask : idle
  initial
  begin
    {clk_sys, rst, fault_line_in, line_enable, slow, bad} = 12'h7fc;
    cmd_in = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(16'h0000);
    acc(1'b1, 16'h3f87);
    rd(16'h0780);
    cmp("ivl", 40'(interval_cycles), 40'h1312d00);
    cmp("dep", 40'(depth_cycles), 40'h3938700);
    cmp("fresh", 40'(nv_out.fresh), 40'h1);
    for (int k = 0; k < 5; k++)
    begin
      acc(1'b1, k == 0 ? 16'h8400 : 16'h8000);
      if (k < 4) rd(k == 0 ? 16'h8400 : 16'h8000);
      idle;
      rd(k == 0 ? 16'h0400 : 16'h0000);
      cmp("rec", 40'(nv_addr), 40'(k < 4 ? k + 1 : 4));
    end
    cmp("cnv", 40'(convs), 40'h1);
    @(posedge clk_sys) slow <= 1'b1;
    acc(1'b1, 16'h8200);
    idle;
    cmp("rec", 40'(nv_addr), 40'h3);
    @(posedge clk_sys) bad <= 1'b1;
    acc(1'b1, 16'h8000);
    idle;
    cmp("err", 40'(comms_memory_error_flag), 40'h1);
    @(posedge clk_sys) {slow, bad} <= 2'h0;
    acc(1'b1, 16'h4000);
    repeat (3) @(posedge clk_sys);
    #1 cmp("hold", 40'(monitor_hold), 40'h1);
    for (int i = 0; i < 4000 && monitor_hold !== 1'b0; i++) #8;
    cmp("ers", 40'(dones), 40'h100);
    rd(16'h0000);
    cmp("rec", 40'(nv_addr), 40'h0);
    acc(1'b1, 16'h0040);
    for (int t = 0; t < 3; t++)
    begin
      @(posedge clk_sys) line_enable <= t == 2 ? 4'he : 4'hf;
      fault_line_in <= t == 1 ? 4'hd : 4'he;
      idle;
      cmp("rec", 40'(nv_addr), 40'h1);
      @(posedge clk_sys) fault_line_in <= 4'hf;
      repeat (4) @(posedge clk_sys);
    end
    cmp("ivl", 40'(interval_cycles), 40'(fault_log_pkg::span_ms_0 * fault_log_pkg::cyc_per_ms));
    cmp("fresh", 40'(nv_out.fresh), 40'h0);
    give_verdict;
  end
endmodule : fault_log_control_bench
bind fault_log_control fault_log_monitor mon_u (
  .clk_sys(clk_sys),
  .rst(rst),
  .cmd_in(cmd_in),
  .cmd_rdata(cmd_rdata),
  .cmd_rvalid(cmd_rvalid),
  .nv_done(nv_done),
  .nv_error(nv_error),
  .nv_out(nv_out),
  .nv_addr(nv_addr),
  .monitor_hold(monitor_hold),
  .comms_memory_error_flag(comms_memory_error_flag),
  .comms_detail_status(comms_detail_status),
  .interval_cycles(interval_cycles),
  .depth_cycles(depth_cycles)
);
`default_nettype wire
